// ==== design/sszecc_top.sv ====
/*
 * SDRAM sizing support and ECC syndrome logging: control, block enable,
 * size and base registers, a free-running counter, periodic refresh and
 * syndrome capture on each checked read word with a nonzero syndrome, all behind Avalon-MM.
 * Assumes read data and check bits arrive on clock_i from the memory
 * path, and that software runs the sizing walk over the registers.
 */
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module sszecc_top (
    input  wire logic        clock_i,         // 100 MHz clock
    input  wire logic        reset_n_i,       // Async reset, active low
    input  wire logic [3:0]  avs_address_i,   // Word index
    input  wire logic        avs_read_i,      // Read request
    input  wire logic        avs_write_i,     // Write request
    input  wire logic [31:0] avs_writedata_i, // Write data
    input  wire logic [3:0]  avs_byteenable_i,// Byte lanes
    output logic      [31:0] avs_readdata_o,  // Read data
    output logic             avs_waitrequest_o,// Stall
    input  wire logic [63:0] rd_data_i,       // Memory read data
    input  wire logic [7:0]  rd_check_i,      // Memory check bits
    input  wire logic        rd_valid_i,      // Read word valid
    output logic      [63:0] rd_data_o,       // Corrected data
    output logic             rd_valid_o,      // Corrected data valid
    output logic             refresh_o,       // Refresh request pulse
    output logic      [7:0]  block_en_o,      // Block enables A..H
    output logic      [31:0] block_size_o,    // Canonical size codes
    output logic      [63:0] block_base_o     // Base bits per block
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    // Release through two flops so reset leaves on a clean edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Merge write data under byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    // Fold encodings that the controller treats alike
    function automatic logic [3:0] canon_size(input logic [3:0] s);
        logic [3:0] r;
        r = s;
        if (s == sszecc_pkg::SIZE_16MX4) begin
            r = sszecc_pkg::SIZE_16MX8;
        end else if (s == sszecc_pkg::SIZE_8MX8) begin
            r = sszecc_pkg::SIZE_8MX16;
        end
        return r;
    endfunction : canon_size

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sszecc_pkg::sszecc_ctrl_t ctrl_ff, nxt_ctrl;
    sszecc_pkg::sszecc_syn_t  syn;
    logic [7:0]  blk_en_ff,    nxt_blk_en;
    logic [31:0] blk_size_ff,  nxt_blk_size;
    logic [31:0] base_lo_ff,   nxt_base_lo;
    logic [31:0] base_hi_ff,   nxt_base_hi;
    logic [7:0]  clk_freq_ff,  nxt_clk_freq;
    logic [31:0] counter_ff,   nxt_counter;
    logic [31:0] ref_count_ff, nxt_ref_count;
    logic [15:0] ref_timer_ff, nxt_ref_timer;
    logic        refresh_ff,   nxt_refresh;
    logic [17:0] ecc_stat_ff,  nxt_ecc_stat;
    logic [31:0] eff_size_ff,  nxt_eff_size;
    logic [31:0] rdata_ff,     nxt_rdata;
    logic        wait_ff,      nxt_wait;
    logic [63:0] rd_data_ff,   nxt_rd_data;
    logic        rd_valid_ff,  nxt_rd_valid;
    logic        req, acc, wr_acc;
    logic [15:0] ref_interval;
    logic [31:0] eff_size_c;
    // Status field positions, shortened for the datapath
    localparam int STAT_SB = sszecc_pkg::STAT_SINGLE_BIT;
    localparam int STAT_MB = sszecc_pkg::STAT_MULTI_BIT;
    localparam int STAT_IX = sszecc_pkg::STAT_INDEX_LSB;
    localparam int STAT_CK = sszecc_pkg::STAT_CHECK_BIT;
    localparam int STAT_NB = sszecc_pkg::STAT_NAMED_BIT;

    sszecc_syndrome u_syndrome (
        .data_i  (rd_data_i),
        .check_i (rd_check_i),
        .syn_o   (syn)
    );

    // Canonical size code per block
    for (genvar g = 0; g < 8; g++) begin : g_canon
        assign eff_size_c[g*4 +: 4] = canon_size(blk_size_ff[g*4 +: 4]);
    end

    assign req = avs_read_i | avs_write_i;
    assign acc = req & wait_ff;
    assign wr_acc = avs_write_i & ~wait_ff;
    // Refresh period follows the programmed clock rate
    assign ref_interval = 16'({8'h00, clk_freq_ff} * {8'h00,
                              sszecc_pkg::REFRESH_US_W});

    // ------------------------------------------------------------------
    // Bus slave and registers: next values
    // ------------------------------------------------------------------
    // Request answered one cycle after it is seen; write lands then
    always_comb begin
        nxt_wait     = ~acc;
        nxt_rdata    = rdata_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_blk_en   = blk_en_ff;
        nxt_blk_size = blk_size_ff;
        nxt_base_lo  = base_lo_ff;
        nxt_base_hi  = base_hi_ff;
        nxt_clk_freq = clk_freq_ff;
        if (acc && avs_read_i) begin
            unique case (avs_address_i)
                sszecc_pkg::REG_CTRL:      nxt_rdata = {16'h0000, ctrl_ff};
                sszecc_pkg::REG_BLK_EN:    nxt_rdata = {24'h0, blk_en_ff};
                sszecc_pkg::REG_BLK_SIZE:  nxt_rdata = blk_size_ff;
                sszecc_pkg::REG_BASE_LO:   nxt_rdata = base_lo_ff;
                sszecc_pkg::REG_BASE_HI:   nxt_rdata = base_hi_ff;
                sszecc_pkg::REG_COUNTER:   nxt_rdata = counter_ff;
                sszecc_pkg::REG_REF_COUNT: nxt_rdata = ref_count_ff;
                sszecc_pkg::REG_ECC_STAT:  nxt_rdata = {14'h0, ecc_stat_ff};
                sszecc_pkg::REG_EFF_SIZE:  nxt_rdata = eff_size_ff;
                sszecc_pkg::REG_CLK_FREQ:  nxt_rdata = {24'h0, clk_freq_ff};
                default:                   nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            unique case (avs_address_i)
                sszecc_pkg::REG_CTRL:
                    nxt_ctrl = 16'(merge_be({16'h0000, ctrl_ff},
                                   avs_writedata_i, avs_byteenable_i));
                sszecc_pkg::REG_BLK_EN:
                    nxt_blk_en = 8'(merge_be({24'h0, blk_en_ff},
                                     avs_writedata_i, avs_byteenable_i));
                sszecc_pkg::REG_BLK_SIZE:
                    nxt_blk_size = merge_be(blk_size_ff, avs_writedata_i,
                                            avs_byteenable_i);
                sszecc_pkg::REG_BASE_LO:
                    nxt_base_lo = merge_be(base_lo_ff, avs_writedata_i,
                                           avs_byteenable_i);
                sszecc_pkg::REG_BASE_HI:
                    nxt_base_hi = merge_be(base_hi_ff, avs_writedata_i,
                                           avs_byteenable_i);
                sszecc_pkg::REG_CLK_FREQ:
                    nxt_clk_freq = 8'(merge_be({24'h0, clk_freq_ff},
                                       avs_writedata_i, avs_byteenable_i));
                default: ;  // Read-only or unmapped: ignored; status flag clears are handled below
            endcase
        end
    end

    // Register bank
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff     <= 1'b1;
            rdata_ff    <= 32'h0000_0000;
            ctrl_ff     <= sszecc_pkg::CTRL_RESET;
            blk_en_ff   <= 8'h00;
            blk_size_ff <= 32'h0000_0000;
            base_lo_ff  <= 32'h0000_0000;
            base_hi_ff  <= 32'h0000_0000;
            clk_freq_ff <= sszecc_pkg::CLK_FREQ_RESET;
        end else begin
            wait_ff     <= nxt_wait;
            rdata_ff    <= nxt_rdata;
            ctrl_ff     <= nxt_ctrl;
            blk_en_ff   <= nxt_blk_en;
            blk_size_ff <= nxt_blk_size;
            base_lo_ff  <= nxt_base_lo;
            base_hi_ff  <= nxt_base_hi;
            clk_freq_ff <= nxt_clk_freq;
        end
    end

    // ------------------------------------------------------------------
    // Counter, refresh and ECC datapath: next values
    // ------------------------------------------------------------------
    // Status flags: hardware set wins over a same-cycle clear
    always_comb begin
        nxt_counter   = counter_ff + 32'h0000_0001;
        nxt_ref_timer = ref_timer_ff + 16'h0001;
        nxt_refresh   = 1'b0;
        nxt_ref_count = ref_count_ff;
        nxt_eff_size  = eff_size_c;
        nxt_ecc_stat  = ecc_stat_ff;
        nxt_rd_data   = rd_data_ff;
        nxt_rd_valid  = rd_valid_i;
        // Timer keeps running so a refresh comes due per interval
        if (ref_timer_ff >= ref_interval - 16'h0001) begin
            nxt_ref_timer = 16'h0000;
            if (!ctrl_ff.refresh_disable && (blk_en_ff != 8'h00)) begin
                nxt_refresh   = 1'b1;
                nxt_ref_count = ref_count_ff + 32'h0000_0001;
            end
        end
        // Write one to bits 8 or 9 clears the sticky flags
        if (wr_acc && avs_address_i == sszecc_pkg::REG_ECC_STAT
            && avs_byteenable_i[1]) begin
            if (avs_writedata_i[STAT_SB]) begin
                nxt_ecc_stat[STAT_SB] = 1'b0;
            end
            if (avs_writedata_i[STAT_MB]) begin
                nxt_ecc_stat[STAT_MB] = 1'b0;
            end
        end
        if (rd_valid_i) begin
            nxt_rd_data = rd_data_i;
            // Raw check-bit access turns checking off for the word
            if (!ctrl_ff.check_bit_raw_access
                && syn.syndrome != 8'h00) begin
                if (syn.named) begin
                    nxt_ecc_stat[7:0] = syn.syndrome;
                    nxt_ecc_stat[STAT_SB] = 1'b1;
                    nxt_ecc_stat[STAT_IX +: 6] = syn.index;
                    nxt_ecc_stat[STAT_CK] = syn.is_check;
                    nxt_ecc_stat[STAT_NB] = 1'b1;
                    if (ctrl_ff.ecc_correction_control && !syn.is_check) begin
                        nxt_rd_data[syn.index] = ~rd_data_i[syn.index];
                    end
                end else begin
                    nxt_ecc_stat[7:0] = syn.syndrome;
                    nxt_ecc_stat[STAT_MB] = 1'b1;
                    nxt_ecc_stat[STAT_NB] = 1'b0;
                end
            end
        end
    end

    // Datapath registers
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            counter_ff   <= 32'h0000_0000;
            ref_timer_ff <= 16'h0000;
            refresh_ff   <= 1'b0;
            ref_count_ff <= 32'h0000_0000;
            eff_size_ff  <= 32'h0000_0000;
            ecc_stat_ff  <= 18'h00000;
            rd_data_ff   <= 64'h0000_0000_0000_0000;
            rd_valid_ff  <= 1'b0;
        end else begin
            counter_ff   <= nxt_counter;
            ref_timer_ff <= nxt_ref_timer;
            refresh_ff   <= nxt_refresh;
            ref_count_ff <= nxt_ref_count;
            eff_size_ff  <= nxt_eff_size;
            ecc_stat_ff  <= nxt_ecc_stat;
            rd_data_ff   <= nxt_rd_data;
            rd_valid_ff  <= nxt_rd_valid;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign rd_data_o         = rd_data_ff;
    assign rd_valid_o        = rd_valid_ff;
    assign refresh_o         = refresh_ff;
    assign block_en_o        = blk_en_ff;
    assign block_size_o      = eff_size_ff;
    assign block_base_o      = {base_hi_ff, base_lo_ff};

endmodule : sszecc_top

`default_nettype wire

// ==== design/sszecc_pkg.sv ====
/*
 * Shared constants and types of the SDRAM sizing helper and ECC syndrome
 * logic: register word indices, field positions, reset values, refresh
 * timing and the check-bit column codes of the 64 data bits.
 * Assumes a 32-bit Avalon-MM register bus with word addressing.
 */
package sszecc_pkg;

    // ------------------------------------------------------------------
    // Register word indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_BLK_EN    = 4'h1;
    localparam logic [3:0] REG_BLK_SIZE  = 4'h2;
    localparam logic [3:0] REG_BASE_LO   = 4'h3;
    localparam logic [3:0] REG_BASE_HI   = 4'h4;
    localparam logic [3:0] REG_COUNTER   = 4'h5;
    localparam logic [3:0] REG_REF_COUNT = 4'h6;
    localparam logic [3:0] REG_ECC_STAT  = 4'h7;
    localparam logic [3:0] REG_EFF_SIZE  = 4'h8;
    localparam logic [3:0] REG_CLK_FREQ  = 4'h9;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          STAT_SINGLE_BIT = 8;
    localparam int          STAT_MULTI_BIT  = 9;
    localparam int          STAT_INDEX_LSB  = 10;
    localparam int          STAT_CHECK_BIT  = 16;
    localparam int          STAT_NAMED_BIT  = 17;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam logic [7:0]  CLK_FREQ_RESET  = 8'h64;  // 100 MHz
    localparam logic [3:0]  SIZE_16MX4      = 4'h4;
    localparam logic [3:0]  SIZE_16MX8      = 4'h5;
    localparam logic [3:0]  SIZE_8MX8       = 4'h2;
    localparam logic [3:0]  SIZE_8MX16      = 4'h3;

    // ------------------------------------------------------------------
    // Refresh timing
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 10;
    localparam int         REFRESH_US         = 15;
    localparam logic [7:0] REFRESH_US_W       = 8'(REFRESH_US);
    localparam int         REFRESH_CYC_AT_RST = REFRESH_US * 1000
                                                / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Column codes: code of data bit i sits at [i]
    // ------------------------------------------------------------------
    localparam logic [63:0][7:0] COL_CODE = {
        8'h32, 8'h34, 8'h38, 8'hd3, 8'h54, 8'h58, 8'h98, 8'h94,
        8'h64, 8'h68, 8'h70, 8'ha7, 8'ha8, 8'hb0, 8'h31, 8'h29,
        8'hc8, 8'hd0, 8'he0, 8'h4f, 8'h51, 8'h61, 8'h62, 8'h52,
        8'h91, 8'ha1, 8'hc1, 8'h9e, 8'ha2, 8'hc2, 8'hc4, 8'ha4,
        8'h23, 8'h43, 8'h83, 8'h3d, 8'h45, 8'h85, 8'h89, 8'h49,
        8'h46, 8'h86, 8'h07, 8'h7a, 8'h8a, 8'h0b, 8'h13, 8'h92,
        8'h8c, 8'h0d, 8'h0e, 8'hf4, 8'h15, 8'h16, 8'h26, 8'h25,
        8'h19, 8'h1a, 8'h1c, 8'he9, 8'h2a, 8'h2c, 8'h4c, 8'h4a};

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] scrub_freq;
        logic       multibit_error_machine_check;
        logic [3:0] err_int_en;
        logic       ecc_correction_control;
        logic       check_bit_raw_access;
        logic       refresh_disable;
    } sszecc_ctrl_t;

    typedef struct packed {
        logic [7:0] syndrome;
        logic [5:0] index;
        logic       is_check;
        logic       named;
    } sszecc_syn_t;

endpackage : sszecc_pkg

// ==== design/sszecc_syndrome.sv ====
/*
 * Combinational syndrome generator and decoder for one 72-bit word.
 * Assumes data and stored check bits are stable in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module sszecc_syndrome (
    input  wire logic [63:0]         data_i,  // Read data
    input  wire logic [7:0]          check_i, // Stored check bits
    output var sszecc_pkg::sszecc_syn_t syn_o // Syndrome and decode
);

    logic [7:0] regen;

    // ------------------------------------------------------------------
    // Regenerate check bits and decode
    // ------------------------------------------------------------------
    // Regenerated check bits xor stored check bits
    always_comb begin
        regen = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (data_i[i]) begin
                regen = regen ^ sszecc_pkg::COL_CODE[i];
            end
        end
        syn_o.syndrome = regen ^ check_i;
        syn_o.index    = 6'h00;
        syn_o.is_check = 1'b0;
        syn_o.named    = 1'b0;
        // Zero and unassigned codes never name a bit
        for (int i = 0; i < 64; i++) begin
            if (syn_o.syndrome == sszecc_pkg::COL_CODE[i]) begin
                syn_o.index = 6'(i);
                syn_o.named = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if (syn_o.syndrome == (8'h01 << j)) begin
                syn_o.index    = 6'(j);
                syn_o.is_check = 1'b1;
                syn_o.named    = 1'b1;
            end
        end
    end

endmodule : sszecc_syndrome

`default_nettype wire

// ==== tb/sszecc_top_assertions.sv ====
/* Port checker of sszecc_top: bus answer, read path, refresh, sizes.
   Assumes one clock domain; bound to every sszecc_top instance. */
`timescale 1ns/100ps
`default_nettype none
module sszecc_top_assertions (
    input wire logic        clock_i,           // Clock
    input wire logic        reset_n_i,         // Reset, active low
    input wire logic        avs_read_i,        // Read request
    input wire logic        avs_write_i,       // Write request
    input wire logic        avs_waitrequest_o, // Stall
    input wire logic [63:0] rd_data_i,         // Word in
    input wire logic [7:0]  rd_check_i,        // Check bits in
    input wire logic        rd_valid_i,        // Word in valid
    input wire logic [63:0] rd_data_o,         // Word out
    input wire logic        rd_valid_o,        // Word out valid
    input wire logic        refresh_o,         // Refresh pulse
    input wire logic [7:0]  block_en_o,        // Block enables
    input wire logic [31:0] block_size_o       // Size codes
);
    // ----------------------------------
    // Helper and properties
    // ----------------------------------
    logic pair_code; // Lower code of a same-size pair seen
    always_comb begin
        pair_code = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pair_code |= block_size_o[4*i +: 4] inside {4'h2, 4'h4};
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_size_canon: assert property (!pair_code)
        else $error("size output shows a lower pair code");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("acknowledge longer than one cycle");
    a_word_follows: assert property (rd_valid_i |=> rd_valid_o)
        else $error("read word not passed on");
    a_word_cause: assert property (rd_valid_o |-> $past(rd_valid_i))
        else $error("read word valid without cause");
    a_refresh_gap: assert property (refresh_o |=> !refresh_o [*8])
        else $error("refresh pulses too close");
    a_refresh_block: assert property (refresh_o |->
        $past(block_en_o) != 8'h00)
        else $error("refresh with no block enabled");
    a_zero_clean: assert property (rd_valid_i && rd_data_i == 64'h0 &&
        rd_check_i == 8'h00 |=> rd_data_o == 64'h0)
        else $error("zero syndrome altered data");
    c_word: cover property (rd_valid_o);
    c_refresh: cover property (refresh_o);
    c_read_ack: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : sszecc_top_assertions
bind sszecc_top sszecc_top_assertions sszecc_top_assertions_i (.*);
`default_nettype wire

// ==== tb/sszecc_mem_model.sv ====
/* Memory read path model: one 72-bit word per send, chosen bits flipped.
   Assumes one caller at a time, on the controller clock. */
`timescale 1ns/100ps
`default_nettype none
module sszecc_mem_model (
    input  wire logic        clock_i,    // Controller clock
    output logic      [63:0] rd_data_o,  // Read data
    output logic      [7:0]  rd_check_o, // Stored check bits
    output logic             rd_valid_o  // Word valid
);
    // ----------------------------------
    // Column codes, data bit 63 first
    // ----------------------------------
    localparam logic [511:0] SYN = {
        128'h323438d354589894646870a7a8b03129,
        128'hc8d0e04f5161625291a1c19ea2c2c4a4,
        128'h2343833d458589494686077a8a0b1392,
        128'h8c0d0ef415162625191a1ce92a2c4c4a};
    initial begin
        rd_data_o  = 64'h0;
        rd_check_o = 8'h00;
        rd_valid_o = 1'b0;
    end
    // Code of data bit k, or of check bit k-64
    function automatic logic [7:0] code(input int k);
        return (k < 64) ? SYN[k*8 +: 8] : 8'h01 << (k - 64);
    endfunction : code
    // Flips bits f1, f2 (data 0..63, check 64..71) after coding
    task automatic send(input logic [63:0] d, input int f1, input int f2);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (d[i]) c ^= code(i);
        end
        for (int k = 0; k < 72; k++) begin
            if (k == f1 || k == f2) begin
                if (k < 64) d[k] = ~d[k];
                else c[k-64] = ~c[k-64];
            end
        end
        @(posedge clock_i);
        rd_data_o  <= d;
        rd_check_o <= c;
        rd_valid_o <= 1'b1;
        @(posedge clock_i);
        rd_valid_o <= 1'b0;
        rd_data_o  <= ~d; // Stale word must not pass as data
        rd_check_o <= ~c;
    endtask : send
endmodule : sszecc_mem_model
`default_nettype wire

// ==== tb/test_sszecc_top.sv ====
/* Bench of sszecc_top: reset values, size codes, refresh, syndromes.
   Assumes the memory model and the bound checker beside it. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sszecc_top;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, e, t0;
    logic        wreq, mval, cval, refr;
    logic [63:0] mdat, cdat, pat;
    logic [7:0]  mchk, ben;
    logic [31:0] bsz;
    logic [63:0] base;
    logic [3:0]  sz [6] = '{4'h9, 4'h5, 4'h4, 4'h3, 4'h2, 4'h0};
    logic [3:0]  cz [6] = '{4'h9, 4'h5, 4'h5, 4'h3, 4'h3, 4'h0};
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    always #5 clock_i = ~clock_i;
    // Sole slave here: nothing else decodes the low range
    sszecc_top sszecc_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .rd_data_i(mdat), .rd_check_i(mchk), .rd_valid_i(mval),
        .rd_data_o(cdat), .rd_valid_o(cval), .refresh_o(refr),
        .block_en_o(ben), .block_size_o(bsz), .block_base_o(base));
    sszecc_mem_model sszecc_mem_model_i (.clock_i(clock_i),
        .rd_data_o(mdat), .rd_check_o(mchk), .rd_valid_o(mval));
    // One register access; holds the request until acknowledged
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        adr  <= a;
        wdat <= d;
        wr   <= w;
        rd   <= ~w;
        do @(posedge clock_i); while (wreq !== 1'b0);
        q  = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // Counts refresh pulses over c cycles
    task automatic cnt(input int c, output int m);
        m = 0;
        repeat (c) begin
            @(posedge clock_i);
            m += int'(refr);
        end
    endtask : cnt
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard, well above the expected run of about 950 cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        bus(1'b0, 4'h0, 32'h0);
        `CHK("ctrl reset", 32'h0, q)
        bus(1'b0, 4'h9, 32'h0);
        `CHK("freq reset", 32'h64, q)
        bus(1'b0, 4'hf, 32'h0);
        `CHK("unmapped", 32'h0, q)
        $display("test reset done");
        bus(1'b1, 4'h0, 32'h4);
        bus(1'b1, 4'h4, 32'ha5);
        bus(1'b1, 4'h3, 32'h0);
        bus(1'b1, 4'h1, 32'h1);
        @(posedge clock_i);
        `CHK("enable", 8'h01, ben)
        `CHK("base", {32'ha5, 32'h0}, base)
        // Largest organisation first, then smaller
        foreach (sz[i]) begin
            bus(1'b1, 4'h2, {28'h0, sz[i]});
            bus(1'b0, 4'h8, 32'h0);
            `CHK("eff size", {28'h0, cz[i]}, q)
            `CHK("size out", cz[i], bsz[3:0])
        end
        $display("test sizing done");
        bus(1'b1, 4'h9, 32'h1);
        bus(1'b0, 4'h5, 32'h0);
        t0 = q;
        do @(posedge clock_i); while (refr !== 1'b1);
        cnt(150, n);
        `CHK("refresh on", 10, n)
        bus(1'b0, 4'h5, 32'h0);
        `CHK("counter", 1'b1, (q - t0) >= 32'd100)
        bus(1'b1, 4'h1, 32'h0);
        repeat (2) @(posedge clock_i);
        cnt(40, n);
        `CHK("no block", 0, n)
        bus(1'b1, 4'h1, 32'h1);
        bus(1'b1, 4'h0, 32'h5);
        repeat (2) @(posedge clock_i);
        cnt(40, n);
        `CHK("refresh off", 0, n)
        bus(1'b1, 4'h0, 32'h4);
        $display("test refresh done");
        for (int k = 0; k < 72; k++) begin
            pat = {32'(k) * 32'h9e3779b9, 32'h5a0fc3e1 ^ 32'(k)};
            sszecc_mem_model_i.send(pat, k, -1);
            bus(1'b0, 4'h7, 32'h0);
            e = {14'h0, 1'b1, k > 63, 6'(k % 64), 2'b01,
                 sszecc_mem_model_i.code(k)};
            `CHK("status", e, q)
            `CHK("data out", pat, cdat)
            bus(1'b1, 4'h7, 32'h300);
        end
        sszecc_mem_model_i.send(64'h0, -1, -1);
        bus(1'b0, 4'h7, 32'h0);
        `CHK("clean", 32'h0, q & 32'h300)
        bus(1'b1, 4'h0, 32'h2);
        sszecc_mem_model_i.send(pat, 0, -1);
        bus(1'b0, 4'h7, 32'h0);
        `CHK("raw flags", 32'h0, q & 32'h300)
        `CHK("raw data", pat ^ 64'h1, cdat)
        bus(1'b1, 4'h0, 32'h4);
        sszecc_mem_model_i.send(pat, 0, 1);
        bus(1'b0, 4'h7, 32'h0);
        `CHK("double", 32'h206, q & 32'h203ff)
        $display("test syndrome done");
        report_and_stop();
    end
endmodule : test_sszecc_top
`default_nettype wire
